// [acsp_pkg.sv]
// package of constants for the converter configuration serial port
package acsp_pkg;
    // serial word layout
    localparam int ADDR_W = 5;  // address bits shifted first
    localparam int DATA_W = 11; // data bits after address
    localparam int WORD_W = 16; // bits per serial word
    localparam int NUM_REGS = 32; // address space of the serial port
    localparam logic [10:0] REG_RESET = 11'h000; // every bit clears on reset
    // serial register offsets
    localparam logic [4:0] SER_REG_GLOBAL = 5'h00; // soft reset, reference, power down
    localparam logic [4:0] SER_REG_MODE = 5'h0d; // override, output mode bits
    // field positions in the global register
    localparam int BIT_SOFT_RESET = 10;
    localparam int BIT_REF_INTERNAL = 5;
    localparam int BIT_PDN_GLOBAL = 0;
    // field positions in the mode register
    localparam int BIT_OVERRIDE = 10;
    localparam int BIT_LSB_FIRST = 6;
    localparam int BIT_COARSE_GAIN = 5;
    localparam int BIT_RISE_EDGE = 4;
    localparam int BIT_SER16 = 2;
    localparam int BIT_SDR = 1;
    localparam int BIT_TWO_WIRE = 0;
    // format register and its data format bit
    localparam logic [4:0] SER_REG_FORMAT = 5'h0a;
    localparam int BIT_OFFSET_BIN = 9;
    // strap level codes, ground to full supply
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int APPLY_NS = 100; // write takes effect after the last bit
    localparam int APPLY_CYC = (APPLY_NS * CLK_MHZ) / 1000;
    localparam int RST_MIN_NS = 10; // shortest reset pulse that counts
    localparam int RST_CYC = ((RST_MIN_NS * CLK_MHZ) + 999) / 1000;
    localparam int STRAP_CYC = 4; // settle cycles before straps are latched
endpackage

// [acsp_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module acsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // pins and result
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta; // first stage, read only by the second

    // both stages clear on reset so logic sees a quiet pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // acsp_sync

// [acsp_strap.sv]
// strap level capture after power-up
`timescale 1ns/1ns
module acsp_strap (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // synchronised strap codes
    input  wire logic [7:0] strap_in,
    // latched codes and capture flag
    output logic      [7:0] strap_q,
    output logic            strap_done
);
    logic [3:0] settle; // lets the synchronisers fill before capture

    // capture once after release; later pin motion is ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle     <= 4'h0;
            strap_q    <= 8'h00;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            if (settle == 4'(acsp_pkg::STRAP_CYC)) begin
                strap_q    <= strap_in; // RULE23
                strap_done <= 1'b1;
            end else begin
                settle <= settle + 4'h1;
            end
        end
    end
endmodule // acsp_strap

// [acsp_port.sv]
// serial configuration port with strap decode and register bank
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Operation
// RULE1: shift only while select is low
// RULE2: sample data on shift clock falling edge
// RULE3: every sixteenth falling edge writes the register
// RULE4: partial word at release is discarded
// RULE5: several words per select period allowed
// RULE6: five address bits then eleven data
// RULE7: works at any slow rate or duty
// RULE8: write applies about 100 ns after edge
// RULE9: host resets registers after power-up
// RULE10: reset pulse over 10 ns restores defaults
// RULE11: soft reset bit restores defaults, self-clears
// RULE12: host waits 5 ms before reset
// RULE13: host waits 25 ns before select
// RULE14: straps configure device after power-up
// RULE15: select strap sets reference and coarse gain
// RULE16: interface strap sets rate and wires
// RULE17: serialization strap sets factor and edge
// RULE18: capture edge only in two-wire single-rate
// RULE19: format strap sets order and coding
// RULE20: override bit hands modes to registers
// RULE21: power-down pin forces global power down
// RULE22: any reset clears every register bit
// RULE23: straps captured once as 2-bit codes
// RULE24: select high restarts the bit count
module acsp_port #(
    parameter int SAMPLE_LAG = 1 // not used; data is sampled in the cycle the falling edge is detected
) (
    // system clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // serial pins
    input  wire logic       serial_select_n,
    input  wire logic       serial_clk,
    input  wire logic       config_serial_in,
    input  wire logic       reset_pin,
    // strap pins as 2-bit level codes, and the power-down pin
    input  wire logic [1:0] select_strap,
    input  wire logic [1:0] interface_mode_strap,
    input  wire logic [1:0] serialization_strap,
    input  wire logic [1:0] reserved_strap,
    input  wire logic [1:0] format_strap,
    input  wire logic       power_down_pin,
    // AXI4-Lite write address and data
    input  wire logic [6:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [6:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    // effective configuration
    output logic            global_power_down,
    output logic            ref_internal,
    output logic            coarse_gain_on,
    output logic            sdr_bit_clock,
    output logic            two_wire,
    output logic            serialize_16x,
    output logic            capture_rising,
    output logic            lsb_first,
    output logic            offset_binary,
    output logic            config_valid
);
    // register bank readable over AXI, read only there
    logic [10:0] cfg_reg [acsp_pkg::NUM_REGS];

    // synchronised pins
    logic [4:0] pin_s;
    logic [7:0] strap_s;
    logic [7:0] strap_q;
    logic       strap_done;
    logic       sel_n_s, sclk_s, sdin_s, rst_s, pdn_s;
    assign {sel_n_s, sclk_s, sdin_s, rst_s, pdn_s} = pin_s;

    acsp_sync #(.W(5)) u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({serial_select_n, serial_clk, config_serial_in, reset_pin, power_down_pin}),
        .sync_out (pin_s)
    );
    // straps go through the same two-stage path before capture
    acsp_sync #(.W(8)) u_strap_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({select_strap, interface_mode_strap, serialization_strap, format_strap}),
        .sync_out (strap_s)
    );
    acsp_strap u_strap (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .strap_in   (strap_s),
        .strap_q    (strap_q),
        .strap_done (strap_done)
    );

    // reserved strap has no function; its level is ignored
    logic unused_reserved;
    assign unused_reserved = ^reserved_strap;

    // shift clock edge detect on synchronised copies
    logic sclk_d;
    wire  sclk_fall = sclk_d && !sclk_s; // RULE2 RULE7

    // shifter state
    logic [15:0] shift_word;
    logic [3:0]  bit_cnt;
    logic        word_ready;
    logic [6:0]  apply_cnt;
    logic        rst_hi;
    logic [2:0]  rst_len;
    logic [15:0] held_word; // finished word, kept while the next one shifts
    wire  [15:0] next_shift = {shift_word[14:0], sdin_s};
    wire  [4:0]  word_addr  = held_word[15:11]; // RULE6
    wire  [10:0] word_data  = held_word[10:0];
    wire         word_done  = sclk_fall && !sel_n_s && (bit_cnt == 4'hf);
    wire         apply_now  = word_ready && (apply_cnt == 7'(acsp_pkg::APPLY_CYC - 1));
    wire         soft_reset = apply_now && (word_addr == acsp_pkg::SER_REG_GLOBAL)
                              && word_data[acsp_pkg::BIT_SOFT_RESET];
    // pin reset counts once held for the least width
    wire         hard_reset = rst_s && (({1'b0, rst_len} + 4'h1) >= 4'(acsp_pkg::RST_CYC)); // RULE10
    wire         bank_clear = hard_reset || soft_reset; // RULE22 RULE11

    // bit shifter: edge detect, shift, count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d     <= 1'b0; // matches the cleared synchroniser, no false edge
            shift_word <= 16'h0000;
            bit_cnt    <= 4'h0;
        end else begin
            sclk_d <= sclk_s;
            if (sel_n_s) begin
                bit_cnt <= 4'h0; // RULE24 RULE4
            end else if (sclk_fall) begin
                shift_word <= next_shift; // RULE1
                bit_cnt    <= bit_cnt + 4'h1; // wraps for chained words RULE5
            end
        end
    end

    // word hold and apply delay; the word is latched so the next word may shift
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_ready <= 1'b0;
            apply_cnt  <= 7'h00;
            held_word  <= 16'h0000;
        end else if (word_done) begin
            word_ready <= 1'b1; // RULE3
            apply_cnt  <= 7'h00;
            held_word  <= next_shift;
        end else if (word_ready) begin
            apply_cnt <= apply_cnt + 7'h01; // RULE8
            if (apply_now) begin
                word_ready <= 1'b0;
            end
        end
    end

    // pin reset pulse width measurement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_len <= 3'h0;
        end else if (!rst_s) begin
            rst_len <= 3'h0;
        end else if (rst_len != 3'h7) begin
            rst_len <= rst_len + 3'h1;
        end
    end
    assign rst_hi = hard_reset;

    // register bank update; the soft reset bit never stays set
    wire [4:0]  held_addr = held_word[15:11];
    wire [10:0] held_data = held_word[10:0];
    genvar gi;
    generate
        for (gi = 0; gi < acsp_pkg::NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn || bank_clear) begin
                    cfg_reg[gi] <= acsp_pkg::REG_RESET; // RULE22
                end else if (apply_now && held_addr == 5'(gi)) begin
                    cfg_reg[gi] <= held_data; // RULE3
                end
            end
        end
    endgenerate

    // strap decode
    wire [1:0] st_sel  = strap_q[7:6];
    wire [1:0] st_if   = strap_q[5:4];
    wire [1:0] st_ser  = strap_q[3:2];
    wire [1:0] st_fmt  = strap_q[1:0];
    // RULE15: external 0, external 3.5, internal 3.5, internal 0 dB
    wire pin_ref_int   = (st_sel == acsp_pkg::LVL_HIGH) || (st_sel == acsp_pkg::LVL_FULL);
    wire pin_coarse    = (st_sel == acsp_pkg::LVL_LOW) || (st_sel == acsp_pkg::LVL_HIGH);
    // RULE16: low-middle level unused, keeps the ground default RULE23
    wire pin_sdr       = (st_if == acsp_pkg::LVL_HIGH);
    wire pin_two_wire  = (st_if == acsp_pkg::LVL_HIGH) || (st_if == acsp_pkg::LVL_FULL);
    // RULE17
    wire pin_ser16     = (st_ser == acsp_pkg::LVL_LOW) || (st_ser == acsp_pkg::LVL_HIGH);
    wire pin_rise      = (st_ser == acsp_pkg::LVL_HIGH) || (st_ser == acsp_pkg::LVL_FULL);
    // RULE19
    wire pin_lsb       = (st_fmt == acsp_pkg::LVL_HIGH) || (st_fmt == acsp_pkg::LVL_FULL);
    wire pin_offset    = (st_fmt == acsp_pkg::LVL_LOW) || (st_fmt == acsp_pkg::LVL_HIGH);

    // register versus pin priority
    wire [10:0] r_glb  = cfg_reg[acsp_pkg::SER_REG_GLOBAL];
    wire [10:0] r_mode = cfg_reg[acsp_pkg::SER_REG_MODE];
    wire [10:0] r_fmt  = cfg_reg[acsp_pkg::SER_REG_FORMAT];
    wire ovrd          = r_mode[acsp_pkg::BIT_OVERRIDE]; // RULE20
    wire eff_sdr       = ovrd ? r_mode[acsp_pkg::BIT_SDR] : pin_sdr;
    wire eff_two       = ovrd ? r_mode[acsp_pkg::BIT_TWO_WIRE] : pin_two_wire;
    wire eff_rise_raw  = ovrd ? r_mode[acsp_pkg::BIT_RISE_EDGE] : pin_rise;
    wire eff_rise      = eff_rise_raw && eff_sdr && eff_two; // RULE18
    wire eff_pdn       = pdn_s || r_glb[acsp_pkg::BIT_PDN_GLOBAL]; // RULE21

    // configuration outputs, registered; valid once straps are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_power_down <= 1'b0;
            ref_internal      <= 1'b0;
            coarse_gain_on    <= 1'b0;
            sdr_bit_clock     <= 1'b0;
            two_wire          <= 1'b0;
            serialize_16x     <= 1'b0;
            capture_rising    <= 1'b0;
            lsb_first         <= 1'b0;
            offset_binary     <= 1'b0;
            config_valid      <= 1'b0;
        end else begin
            global_power_down <= eff_pdn; // RULE21
            ref_internal      <= ovrd ? r_glb[acsp_pkg::BIT_REF_INTERNAL] : pin_ref_int; // RULE15
            coarse_gain_on    <= ovrd ? r_mode[acsp_pkg::BIT_COARSE_GAIN] : pin_coarse; // RULE20
            sdr_bit_clock     <= eff_sdr; // RULE16
            two_wire          <= eff_two;
            serialize_16x     <= ovrd ? r_mode[acsp_pkg::BIT_SER16] : pin_ser16; // RULE17
            capture_rising    <= eff_rise; // RULE18
            lsb_first         <= ovrd ? r_mode[acsp_pkg::BIT_LSB_FIRST] : pin_lsb; // RULE19
            offset_binary     <= ovrd ? r_fmt[acsp_pkg::BIT_OFFSET_BIN] : pin_offset;
            config_valid      <= strap_done; // RULE14
        end
    end

    // AXI4-Lite slave: registers are read only, writes answer SLVERR
    logic aw_got, w_got;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awready && s_axi_awvalid) aw_got <= 1'b1;
            if (s_axi_wready && s_axi_wvalid) w_got <= 1'b1;
            if (aw_got && w_got && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h2;
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    wire unused_w = ^{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, rst_hi, unused_reserved};

    // read: word index is address bits 6:2, bits above 10 read zero
    wire [4:0]  rd_idx  = s_axi_araddr[6:2];
    wire [31:0] rd_word = {21'h000000, cfg_reg[rd_idx]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // acsp_port

// [acsp_host.sv]
// host model driving the three-wire configuration link
`timescale 1ns/1ns
module acsp_host (
    // pacing clock
    input  wire logic aclk,
    // link pins
    output logic      serial_select_n,
    output logic      serial_clk,
    output logic      config_serial_in
);
    // deselected, shift clock parked low between frames
    initial begin
        serial_select_n = 1'b1;
        serial_clk = 1'b0;
        config_serial_in = 1'b0;
    end
    // select low, with setup time before the first falling edge
    task automatic open_frame();
        serial_select_n <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // bit launched with the rising edge, held across the falling one
    task automatic send_bit(input logic b, input int hi, input int lo);
        config_serial_in <= b;
        serial_clk <= 1'b1;
        repeat (hi) @(posedge aclk);
        serial_clk <= 1'b0;
        repeat (lo) @(posedge aclk);
    endtask
    // address first, top bit leading; words may chain in one frame
    task automatic send_word(input logic [15:0] w, input int hi, input int lo);
        for (int i = 15; i >= 0; i--) begin
            send_bit(w[i], hi, lo);
        end
    endtask
    // release select; the data line stops holding its last bit
    task automatic close_frame();
        serial_select_n <= 1'b1;
        config_serial_in <= ~config_serial_in;
        @(posedge aclk);
    endtask
endmodule // acsp_host

// [acsp_port_properties.sv]
// concurrent checks on the configuration serial port
`timescale 1ns/1ns
module acsp_port_properties (
    // clock, reset and pins
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        serial_select_n,
    input wire logic        reset_pin,
    input wire logic        power_down_pin,
    // configuration and bus answers
    input wire logic        global_power_down,
    input wire logic        two_wire,
    input wire logic        offset_binary,
    input wire logic        config_valid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    // one domain: the system clock and its reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ten quiet cycles leave room for a word still being applied
    a_select_gates_shift: assert property ((serial_select_n && !reset_pin && config_valid)[*8] ##1
        (serial_select_n && !reset_pin && config_valid)[*2] |-> $stable({two_wire, offset_binary}))
        else $error("modes moved while deselected");
    a_pin_forces_pdn: assert property (power_down_pin && config_valid |-> ##[1:3] global_power_down)
        else $error("power down pin ignored");
    a_straps_latched: assert property (config_valid |=> config_valid)
        else $error("capture flag dropped");
    a_rdata_eleven: assert property (s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h0 && s_axi_rresp == 2'h0)
        else $error("read data wider than a register");
    a_read_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h2)
        else $error("write not refused");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    // main scenarios reached
    c_pin_pdn: cover property (power_down_pin ##1 global_power_down);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // acsp_port_properties

bind acsp_port acsp_port_properties u_acsp_port_properties (
    .aclk, .aresetn, .serial_select_n, .reset_pin, .power_down_pin, .global_power_down,
    .two_wire, .offset_binary, .config_valid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready
);

// [acsp_port_tb.sv]
// self-checking bench for the configuration serial port
`timescale 1ns/1ns
module acsp_port_tb;
    // driven inputs; one level is shared by every strap but the reserved one, which gets its inverse
    logic aclk = 1'b0, aresetn = 1'b0, reset_pin = 1'b0, power_down_pin = 1'b0;
    logic [1:0] strap = 2'h0;
    logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    // answers of the port
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, aw, w;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic serial_select_n, serial_clk, config_serial_in, global_power_down, config_valid;
    logic ref_internal, coarse_gain_on, sdr_bit_clock, two_wire, serialize_16x;
    logic capture_rising, lsb_first, offset_binary;
    wire logic [7:0] cfg = {ref_internal, coarse_gain_on, sdr_bit_clock, two_wire,
                            serialize_16x, capture_rising, lsb_first, offset_binary};
    int bad_count = 0;
    int checks = 0;
    acsp_port u_acsp_port (
        .aclk, .aresetn, .serial_select_n, .serial_clk, .config_serial_in, .reset_pin,
        .select_strap(strap), .interface_mode_strap(strap), .serialization_strap(strap),
        .reserved_strap(~strap), .format_strap(strap), .power_down_pin,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .global_power_down, .ref_internal, .coarse_gain_on,
        .sdr_bit_clock, .two_wire, .serialize_16x, .capture_rising, .lsb_first,
        .offset_binary, .config_valid
    );
    acsp_host u_acsp_host (.aclk, .serial_select_n, .serial_clk, .config_serial_in);
    always #10 aclk = ~aclk;
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        give_verdict();
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // decoded modes per level; level 1 of the interface strap keeps the ground setting
    function automatic logic [7:0] strap_exp(input logic [1:0] l);
        logic m, h, s;
        m = (l == 2'h1 || l == 2'h2);
        h = (l >= 2'h2);
        s = (l == 2'h2);
        return {h, m, s, h, m, s, h, m};
    endfunction
    // power-up with straps at one level, then wait for capture
    task automatic power_up(input logic [1:0] l);
        aresetn <= 1'b0;
        strap <= l;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int n = 0; n < 50 && config_valid !== 1'b1; n++) @(posedge aclk);
        // register reset pulse, long after power-up; supply delay scaled down
        reset_pin <= 1'b1;
        @(posedge aclk);
        reset_pin <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // one word in its own frame, then time for it to apply
    task automatic ser(input logic [15:0] v);
        u_acsp_host.open_frame();
        u_acsp_host.send_word(v, 4, 4);
        u_acsp_host.close_frame();
        repeat (16) @(posedge aclk);
    endtask
    // bus read with a late rready, compared on arrival
    task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(what, s_axi_rdata, exp);
    endtask
    // straps decode at capture and ignore later moves
    task automatic t_straps(input logic [1:0] l);
        power_up(l);
        check("strap modes", {config_valid, cfg}, {1'b1, strap_exp(l)});
        strap <= ~l;
        repeat (8) @(posedge aclk);
        check("strap hold", cfg, strap_exp(l));
    endtask
    // three chained words under override
    task automatic t_chain();
        u_acsp_host.open_frame();
        u_acsp_host.send_word({5'h0d, 11'h477}, 4, 4);
        u_acsp_host.send_word({5'h0a, 11'h200}, 4, 4);
        u_acsp_host.send_word({5'h00, 11'h021}, 4, 4);
        u_acsp_host.close_frame();
        repeat (16) @(posedge aclk);
        check("modes", cfg, 8'hff);
        check("pdn bit", global_power_down, 1'b1);
        rd(7'h34, 32'h477, "mode reg");
        rd(7'h28, 32'h200, "format reg");
        rd(7'h00, 32'h021, "global reg");
    endtask
    // shifts while deselected, a partial word, then uneven slow shift clock
    task automatic t_partial();
        for (int i = 0; i < 16; i++) u_acsp_host.send_bit(1'b1, 3, 3);
        u_acsp_host.open_frame();
        for (int i = 0; i < 5; i++) u_acsp_host.send_bit(1'b1, 3, 9);
        u_acsp_host.close_frame();
        u_acsp_host.open_frame();
        u_acsp_host.send_word({5'h0a, 11'h000}, 3, 9);
        u_acsp_host.close_frame();
        repeat (16) @(posedge aclk);
        rd(7'h7c, 32'h0, "stray reg");
        rd(7'h28, 32'h0, "format reg");
    endtask
    // soft reset, then a one-cycle pin pulse
    task automatic t_resets();
        ser({5'h00, 11'h400});
        rd(7'h00, 32'h0, "soft reset bit");
        rd(7'h34, 32'h0, "mode after soft");
        check("straps back", cfg, strap_exp(2'h0));
        ser({5'h0d, 11'h477});
        check("modes again", cfg, 8'h7e);
        reset_pin <= 1'b1;
        @(posedge aclk);
        reset_pin <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(7'h34, 32'h0, "mode after pin");
        check("modes after pin", cfg, strap_exp(2'h0));
    endtask
    // pin power down, then a refused bus write
    task automatic t_pin_and_write();
        power_down_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        check("pin pdn", global_power_down, 1'b1);
        power_down_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        check("pin released", global_power_down, 1'b0);
        {aw, w} = 2'b00;
        {s_axi_awaddr, s_axi_wdata} <= {7'h34, 32'h477};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) aw = 1'b1;
            if (s_axi_wready === 1'b1) w = 1'b1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("write resp", s_axi_bresp, 2'h2);
        rd(7'h34, 32'h0, "mode after write");
    endtask
    initial begin
        for (int l = 3; l >= 0; l--) t_straps(2'(l));
        t_chain();
        t_partial();
        t_resets();
        t_pin_and_write();
        give_verdict();
    end
endmodule // acsp_port_tb
